// File: hw/rti_pkg.sv
// rti_pkg: shared constants and types of the response error injector
// assumes a 50 MHz ref_clk and a word-wide AHB-Lite register port
// How it works
// - status sync swapped for configured pattern
// - selected data word uses configured sync
// - parity bit inverted on selected word
// - one chosen bit held high or low
// - idle gap inserted after selected word
// - one extra data word sent
// - one data word fewer sent
// - one to three extra bits appended
// - selected word shortened by 1-3 bits
// - response goes out on other bus
// - mid-bit crossing moved early, four steps
// - mid-bit crossing moved late, four steps
// - one fault type per subaddress entry
// - busy or message error: status only
// - next status shared by all subaddresses
// - per-subaddress mask ORed into status
// - busy and message error at fixed positions
// - end-of-transfer pulse when enabled
// - transfer-error pulse when enabled
// - last status kept, broadcast flag set
`default_nettype none
package rti_pkg;
   // ******************************
   // timing
   // ******************************
   localparam int CLK_MHZ = 50;
   localparam int BIT_NS = 1000;
   localparam int BIT_CYC = BIT_NS * CLK_MHZ / 1000;
   localparam logic [5:0] BIT_LAST = 6'(BIT_CYC - 1);
   localparam logic [5:0] HALF_CYC = 6'(BIT_CYC / 2);
   localparam int RESP_NS = 6000;
   localparam logic [15:0] RESP_LD = 16'(RESP_NS * CLK_MHZ / 1000 - 1);
   localparam int ZC_STEP_NS = 40;
   localparam logic [5:0] ZC_STEP = 6'((ZC_STEP_NS * CLK_MHZ + 999) / 1000);
   // ******************************
   // word layout
   // ******************************
   localparam logic [5:0] SYNC_CMD = 6'h38;
   localparam logic [5:0] SYNC_DATA = 6'h07;
   localparam logic [4:0] SYNC_SLOTS = 5'h03;
   localparam logic [4:0] WORD_SLOTS = 5'h14;
   localparam logic [15:0] ST_BUSY = 16'h0008;
   localparam logic [15:0] ST_MERR = 16'h0800;
   localparam logic [15:0] ST_BCAST = 16'h0010;
   localparam logic [15:0] NEXT_RST = 16'h0000;
   // ******************************
   // register map
   // ******************************
   localparam logic [7:0] A_SEL = 8'h00;
   localparam logic [7:0] A_FAULT = 8'h04;
   localparam logic [7:0] A_SACTL = 8'h08;
   localparam logic [7:0] A_NEXT = 8'h0C;
   localparam logic [7:0] A_LAST = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   typedef enum logic [3:0] {
      FLT_NONE, FLT_STAT_SYNC, FLT_DATA_SYNC, FLT_PARITY, FLT_STUCK_HI,
      FLT_STUCK_LO, FLT_GAP, FLT_WC_HIGH, FLT_WC_LOW, FLT_BC_HIGH,
      FLT_BC_LOW, FLT_ALT_BUS, FLT_ZC_LOW, FLT_ZC_HIGH
   } rti_fault_type_t;
   typedef struct packed {
      logic [6:0] gap;
      logic [5:0] wpos;
      logic [4:0] bpos;
      logic [1:0] dev;
      logic [1:0] fault_bit_count;
      logic [5:0] sync;
      logic [3:0] ftype;
   } rti_fault_t;
   typedef struct packed {
      logic [12:0] rsvd;
      logic transfer_error_irq_enable;
      logic end_of_transfer_irq_enable;
      logic mask_or;
      logic [15:0] mask;
   } rti_sactl_t;
   typedef struct packed {
      logic valid;
      logic bus;
      logic bcast;
      logic tx;
      logic [4:0] sa;
      logic [4:0] wc;
   } rti_cmd_t;
   typedef struct packed {
      logic a_lvl;
      logic a_en;
      logic b_lvl;
      logic b_en;
   } rti_line_t;
   typedef enum logic [1:0] {RT_IDLE, RT_WAIT, RT_SEND, RT_GAP} rti_state_t;
endpackage
`default_nettype wire

// File: hw/rti_injector.sv
// rti_injector: remote terminal response transmitter with fault
// injection and its AHB-Lite register slave
// assumes cmd comes from receive logic on ref_clk and data_word
// answers data_index combinationally in the same cycle
`default_nettype none
module rti_injector
(
   input wire logic ref_clk, // core clock
   input wire logic nrst, // async reset, low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write strobe
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire rti_pkg::rti_cmd_t cmd, // decoded command
   input wire logic [15:0] data_word, // buffer word
   output logic [5:0] data_index, // buffer index
   output rti_pkg::rti_line_t line, // bus drivers
   output logic eot_irq, // end of transfer
   output logic err_irq, // transfer error
   output logic [4:0] irq_sa, // irq subaddress
   output logic xfer_busy // response active
);
   import rti_pkg::*;

   // ******************************
   // register slave
   // ******************************
   logic acc;
   logic ph_wr;
   logic ph_rd;
   logic rd_done;
   logic [7:0] ph_addr;
   logic [4:0] sa_sel;
   logic [15:0] next_status;
   logic [15:0] last_status;
   logic prev_bcast;
   logic [31:0] rd_mux;
   rti_fault_t flt_mem [32];
   rti_sactl_t sac_mem [32];
   rti_state_t st;

   assign acc = hsel && htrans[1] && hready;
   // reads take one wait state so a write just before is already stored
   assign hreadyout = !(ph_rd && !rd_done);
   assign hresp = 1'b0;
   assign xfer_busy = (st != RT_IDLE);

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ph_wr <= 1'b0;
         ph_rd <= 1'b0;
         rd_done <= 1'b0;
         ph_addr <= 8'h00;
      end
      else if (acc)
      begin
         ph_wr <= hwrite && (hsize == 3'h2);
         ph_rd <= !hwrite;
         rd_done <= 1'b0;
         ph_addr <= haddr[7:0];
      end
      else if (hreadyout)
      begin
         ph_wr <= 1'b0;
         ph_rd <= 1'b0;
      end
      else
         rd_done <= 1'b1;
   end

   always_comb
   begin
      case (ph_addr)
         A_SEL: rd_mux = {27'h0000000, sa_sel};
         A_FAULT: rd_mux = flt_mem[sa_sel];
         A_SACTL: rd_mux = sac_mem[sa_sel];
         A_NEXT: rd_mux = {16'h0000, next_status};
         A_LAST: rd_mux = {16'h0000, last_status};
         A_STAT: rd_mux = {24'h000000, xfer_busy, prev_bcast, 1'b0, irq_sa};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         hrdata <= 32'h00000000;
      else if (ph_rd && !rd_done)
         hrdata <= rd_mux;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         sa_sel <= 5'h00;
      else if (ph_wr && ph_addr == A_SEL)
         sa_sel <= hwdata[4:0];
   end

   // one status seed for every subaddress and mode code
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         next_status <= NEXT_RST;
      else if (ph_wr && ph_addr == A_NEXT)
         next_status <= hwdata[15:0];
   end

   // entries are taken at transfer start, so edits mid-response wait
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < 32; i++)
         begin
            flt_mem[i] <= '0;
            sac_mem[i] <= '0;
         end
      end
      else if (ph_wr && ph_addr == A_FAULT)
         flt_mem[sa_sel] <= hwdata;
      else if (ph_wr && ph_addr == A_SACTL)
         sac_mem[sa_sel] <= {13'h0000, hwdata[18:0]};
   end

   // ******************************
   // transfer start
   // ******************************
   rti_fault_t cf;
   rti_sactl_t cs;
   rti_fault_type_t ft;
   rti_fault_type_t nft;
   logic start;
   logic stop;
   logic bus_sel;
   logic [4:0] cur_sa;
   logic [15:0] st_val;
   logic [15:0] status;
   logic [5:0] wc_eff;
   logic [5:0] next_nd;
   logic [5:0] nd;

   assign start = (st == RT_IDLE) && cmd.valid;
   assign nft = rti_fault_type_t'(flt_mem[cmd.sa].ftype);
   assign ft = rti_fault_type_t'(cf.ftype);

   always_comb
   begin
      st_val = next_status | (prev_bcast ? ST_BCAST : 16'h0000);
      if (sac_mem[cmd.sa].mask_or)
         st_val = st_val | sac_mem[cmd.sa].mask;
      stop = |(st_val & (ST_BUSY | ST_MERR));
      wc_eff = (cmd.wc == 5'h00) ? 6'h20 : {1'b0, cmd.wc};
      next_nd = (cmd.tx && !stop) ? wc_eff : 6'h00;
      if (next_nd != 6'h00 && nft == FLT_WC_HIGH)
         next_nd = next_nd + 6'h01;
      else if (next_nd != 6'h00 && nft == FLT_WC_LOW)
         next_nd = next_nd - 6'h01;
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cf <= '0;
         cs <= '0;
         status <= 16'h0000;
         nd <= 6'h00;
         bus_sel <= 1'b0;
         cur_sa <= 5'h00;
      end
      else if (start)
      begin
         cf <= flt_mem[cmd.sa];
         cs <= sac_mem[cmd.sa];
         status <= st_val;
         nd <= next_nd;
         bus_sel <= cmd.bus ^ (nft == FLT_ALT_BUS);
         cur_sa <= cmd.sa;
      end
   end

   // ******************************
   // word sequencing
   // ******************************
   logic [15:0] cnt;
   logic [5:0] widx;
   logic [5:0] ld_idx;
   logic [5:0] cyc;
   logic [4:0] slot;
   logic [4:0] wlen;
   logic [4:0] ld_len;
   logic [19:0] wsh;
   logic [5:0] wsync;
   logic [5:0] ld_sync;
   logic [15:0] ld_bits;
   logic ld_par;
   logic ld_sel;
   logic wsel;
   logic wend;
   logic gap_go;
   logic gap_end;
   logic wait_end;
   logic adv;
   logic last;
   logic do_load;
   logic do_fin;

   assign wait_end = (st == RT_WAIT) && (cnt == 16'h0000);
   assign gap_end = (st == RT_GAP) && (cnt == 16'h0000);
   assign wend = (st == RT_SEND) && (cyc == BIT_LAST) && (slot == wlen - 5'h01);
   assign gap_go = wsel && (ft == FLT_GAP) && (cf.gap != 7'h00);
   assign last = (widx == nd);
   assign adv = (wend && !gap_go) || gap_end;
   assign do_load = wait_end || (adv && !last);
   assign do_fin = adv && last;
   assign ld_idx = wait_end ? 6'h00 : widx + 6'h01;

   always_comb
   begin
      ld_sel = (ld_idx == cf.wpos);
      ld_bits = (ld_idx == 6'h00) ? status : data_word;
      ld_sync = (ld_idx == 6'h00) ? SYNC_CMD : SYNC_DATA;
      if (ld_idx == 6'h00 && ft == FLT_STAT_SYNC)
         ld_sync = cf.sync;
      if (ld_idx != 6'h00 && ld_sel && ft == FLT_DATA_SYNC)
         ld_sync = cf.sync;
      ld_par = ~^ld_bits ^ (ld_sel && ft == FLT_PARITY);
      ld_len = WORD_SLOTS;
      if (ld_sel && ft == FLT_BC_HIGH)
         ld_len = WORD_SLOTS + {3'h0, cf.fault_bit_count};
      if (ld_sel && ft == FLT_BC_LOW)
         ld_len = WORD_SLOTS - {3'h0, cf.fault_bit_count};
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         st <= RT_IDLE;
      else
      begin
         unique case (st)
            RT_IDLE:
               if (start && !cmd.bcast)
                  st <= RT_WAIT;
            RT_WAIT:
               if (wait_end)
                  st <= RT_SEND;
            RT_SEND:
               if (wend && gap_go)
                  st <= RT_GAP;
               else if (do_fin)
                  st <= RT_IDLE;
            RT_GAP:
               if (gap_end)
                  st <= last ? RT_IDLE : RT_SEND;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         cnt <= 16'h0000;
      else if (start)
         cnt <= RESP_LD;
      else if (wend && gap_go)
         cnt <= 16'(cf.gap * BIT_CYC) - 16'h0001;
      else if (cnt != 16'h0000 && (st == RT_WAIT || st == RT_GAP))
         cnt <= cnt - 16'h0001;
   end

   // extra bits beyond parity shift out as manchester zeros
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         widx <= 6'h00;
         cyc <= 6'h00;
         slot <= 5'h00;
         wsh <= 20'h00000;
         wsync <= 6'h00;
         wlen <= WORD_SLOTS;
         wsel <= 1'b0;
         data_index <= 6'h00;
      end
      else if (do_load)
      begin
         widx <= ld_idx;
         cyc <= 6'h00;
         slot <= 5'h00;
         wsh <= {ld_bits, ld_par, 3'h0};
         wsync <= ld_sync;
         wlen <= ld_len;
         wsel <= ld_sel;
         data_index <= ld_idx;
      end
      else if (st == RT_SEND)
      begin
         if (cyc == BIT_LAST)
         begin
            cyc <= 6'h00;
            slot <= slot + 5'h01;
            if (slot < SYNC_SLOTS)
               wsync <= {wsync[3:0], 2'h0};
            else
               wsh <= {wsh[18:0], 1'b0};
         end
         else
            cyc <= cyc + 6'h01;
      end
   end

   // ******************************
   // line encoder
   // ******************************
   logic hit;
   logic lvl;
   logic tx_on;
   logic [1:0] pair;
   logic [5:0] mid;
   logic [5:0] dev_c;

   always_comb
   begin
      hit = wsel && (slot == cf.bpos);
      dev_c = ({4'h0, cf.dev} + 6'h01) * ZC_STEP;
      mid = HALF_CYC;
      if (hit && ft == FLT_ZC_LOW)
         mid = HALF_CYC - dev_c;
      if (hit && ft == FLT_ZC_HIGH)
         mid = HALF_CYC + dev_c;
      pair = (slot < SYNC_SLOTS) ? wsync[5:4] : {wsh[19], !wsh[19]};
      lvl = (cyc < mid) ? pair[1] : pair[0];
      if (hit && ft == FLT_STUCK_HI)
         lvl = 1'b1;
      if (hit && ft == FLT_STUCK_LO)
         lvl = 1'b0;
   end

   assign tx_on = (st == RT_SEND);

   // the idle bus sits low with its driver off, also through a gap
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
         line <= '0;
      else
      begin
         line.a_en <= tx_on && !bus_sel;
         line.a_lvl <= tx_on && !bus_sel && lvl;
         line.b_en <= tx_on && bus_sel;
         line.b_lvl <= tx_on && bus_sel && lvl;
      end
   end

   // ******************************
   // completion and events
   // ******************************
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         eot_irq <= 1'b0;
         err_irq <= 1'b0;
         irq_sa <= 5'h00;
      end
      else
      begin
         eot_irq <= (do_fin && cs.end_of_transfer_irq_enable) ||
            (start && cmd.bcast && sac_mem[cmd.sa].end_of_transfer_irq_enable);
         err_irq <= do_fin && cs.transfer_error_irq_enable && (ft != FLT_NONE);
         if (do_fin)
            irq_sa <= cur_sa;
         else if (start && cmd.bcast)
            irq_sa <= cmd.sa;
      end
   end

   // broadcasts get no reply; the flag rides on the next status word
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prev_bcast <= 1'b0;
         last_status <= 16'h0000;
      end
      else if (start && cmd.bcast)
         prev_bcast <= 1'b1;
      else if (do_fin)
      begin
         prev_bcast <= 1'b0;
         last_status <= status;
      end
   end

   // ******************************
   // checks
   // ******************************
   logic lvl_out;
   assign lvl_out = line.a_lvl | line.b_lvl;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!nrst);

   sequence s_sync_mid(logic first);
      tx_on && (slot == 5'h00) && (cyc == 6'h02) && ((widx == 6'h00) == first);
   endsequence
   sequence s_gap_in;
      wend && gap_go;
   endsequence
   sequence s_quiet4;
      (!line.a_en && !line.b_en) [*4];
   endsequence

   a_stat_sync: assert property (s_sync_mid(1'b1) |=>
      lvl_out == ((ft == FLT_STAT_SYNC) ? cf.sync[5] : SYNC_CMD[5]))
      else $error("status sync level wrong");
   a_data_sync: assert property (s_sync_mid(1'b0) |=>
      lvl_out == ((ft == FLT_DATA_SYNC && wsel) ? cf.sync[5] : SYNC_DATA[5]))
      else $error("data sync level wrong");
   a_parity_odd: assert property (do_load |=>
      ((^wsh[19:3]) == !(wsel && ft == FLT_PARITY)))
      else $error("parity not as configured");
   a_stuck_lvl: assert property (tx_on && hit &&
      (ft == FLT_STUCK_HI || ft == FLT_STUCK_LO) |=> lvl_out == $past(ft == FLT_STUCK_HI))
      else $error("stuck bit level wrong");
   // the line register still shows the last bit one cycle after the word ends
   a_gap_quiet: assert property (s_gap_in |=> ##1 s_quiet4)
      else $error("bus driven during gap");
   a_wc_high: assert property (start && cmd.tx && !stop && nft == FLT_WC_HIGH
      |=> nd == $past(wc_eff) + 6'h01)
      else $error("word count high wrong");
   a_wc_low: assert property (start && cmd.tx && !stop && nft == FLT_WC_LOW
      |=> nd == $past(wc_eff) - 6'h01)
      else $error("word count low wrong");
   a_bc_high: assert property (do_load && ld_sel && ft == FLT_BC_HIGH
      |=> wlen == WORD_SLOTS + {3'h0, cf.fault_bit_count})
      else $error("bit count high wrong");
   a_bc_low: assert property (do_load && ld_sel && ft == FLT_BC_LOW
      |=> wlen == WORD_SLOTS - {3'h0, cf.fault_bit_count})
      else $error("bit count low wrong");
   a_alt_bus: assert property (start && !cmd.bcast |=>
      bus_sel == ($past(cmd.bus) ^ $past(nft == FLT_ALT_BUS)))
      else $error("response bus wrong");
   a_zc_early: assert property (tx_on && hit && ft == FLT_ZC_LOW &&
      cyc == HALF_CYC - 6'h01 |=> lvl_out == $past(pair[0]))
      else $error("crossing not early");
   a_zc_late: assert property (tx_on && hit && ft == FLT_ZC_HIGH &&
      cyc == HALF_CYC |=> lvl_out == $past(pair[1]))
      else $error("crossing not late");
   a_busy_only: assert property (start && stop |=> nd == 6'h00)
      else $error("data sent despite busy");
   a_or_mask: assert property (start |=>
      (status & $past(next_status)) == $past(next_status))
      else $error("next status bits lost");
   a_eot_pulse: assert property (do_fin && cs.end_of_transfer_irq_enable |=> eot_irq)
      else $error("missing end of transfer pulse");
   a_err_pulse: assert property (do_fin && cs.transfer_error_irq_enable &&
      ft != FLT_NONE |=> err_irq)
      else $error("missing transfer error pulse");
   a_bcast_flag: assert property (start && prev_bcast |=> (status & ST_BCAST) != 16'h0000)
      else $error("broadcast flag missing");
endmodule
`default_nettype wire

// File: verif/rti_bc_model.sv
// rti_bc_model: bus controller stand-in that issues command pulses and
// serves the transmit buffer word for whatever index the injector asks for
// assumes the injector samples cmd on the rising edge of ref_clk
`default_nettype none
module rti_bc_model
(
   input wire logic ref_clk, // core clock
   input wire logic xfer_busy, // response in progress
   input wire logic [5:0] data_index, // buffer index asked for
   output var rti_pkg::rti_cmd_t cmd, // command pulse
   output logic [15:0] data_word // buffer word
);
   timeunit 1ns;
   timeprecision 1ps;
   import rti_pkg::*;

   // ************************
   // buffer and command
   // ************************
   // a word pattern unique to each index, so a skipped word changes the wire
   assign data_word = {4'hA, data_index, 6'h15} ^ {data_index, 10'h000};

   initial cmd = '0;

   // commands only go out while the terminal is free, as a real controller would
   task automatic send(input logic bus, input logic bc, input logic tx,
                       input logic [4:0] sa, input logic [4:0] wc);
      while (xfer_busy)
         @(posedge ref_clk);
      @(posedge ref_clk);
      cmd <= '{1'b1, bus, bc, tx, sa, wc};
      @(posedge ref_clk);
      // released fields show garbage, not the last command
      cmd <= {1'b0, ~cmd[12:0]};
   endtask
endmodule
`default_nettype wire

// File: verif/test_rti_injector.sv
// test_rti_injector: self-checking bench for the response error injector
// assumes rti_bc_model stands on the command side and hready = hreadyout
`default_nettype none
module test_rti_injector;
   timeunit 1ns;
   timeprecision 1ps;
   import rti_pkg::*;

   typedef struct packed {
      logic [15:0] cyc;
      logic bus;
      logic [15:0] stw;
      logic err;
      logic [4:0] sa;
   } rti_exp_t;

   localparam int WCYC = 32'(WORD_SLOTS) * BIT_CYC;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, eot_irq, err_irq, xfer_busy;
   logic [31:0] hrdata;
   rti_cmd_t cmd;
   rti_line_t line;
   logic [15:0] data_word;
   logic [5:0] data_index;
   logic [4:0] irq_sa;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int n_sent = 0;
   int n_done = 0;
   int c = 0;
   logic rd_ph = 1'b0;
   logic [31:0] rdq[$];
   rti_exp_t xq[$];
   rti_exp_t got = '0;
   logic [15:0] rnd = 16'hD059;
   logic [15:0] m;

   always #10 ref_clk = ~ref_clk;

   rti_injector rti_injector_i (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd(cmd),
      .data_word(data_word), .data_index(data_index), .line(line), .eot_irq(eot_irq),
      .err_irq(err_irq), .irq_sa(irq_sa), .xfer_busy(xfer_busy));
   rti_bc_model rti_bc_model_i (.ref_clk(ref_clk), .xfer_busy(xfer_busy),
      .data_index(data_index), .cmd(cmd), .data_word(data_word));

   // ************************
   // checking
   // ************************
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD t=%0t read got %h exp %h", $time, g, e);
      end
   endtask

   task automatic cmp_xfer(input rti_exp_t g, input rti_exp_t e);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD t=%0t xfer got %h exp %h", $time, g, e);
      end
   endtask

   // status bits are read in the first half of each data slot of the first word
   always @(posedge ref_clk)
   begin
      if (rd_ph && hreadyout)
      begin
         cmp_rd(hrdata, rdq.pop_front());
         rd_ph = 1'b0;
      end
      if (hsel && htrans[1] && hreadyout && !hwrite)
         rd_ph = 1'b1;
      // once the response has begun, idle gap cycles count too
      if (line.a_en || line.b_en || c != 0)
      begin
         if (c % BIT_CYC == 12 && c / BIT_CYC >= 3 && c / BIT_CYC <= 18)
            got.stw = {got.stw[14:0], line.b_en ? line.b_lvl : line.a_lvl};
         got.bus = got.bus | line.b_en;
         c++;
      end
      if (eot_irq)
      begin
         got.cyc = 16'(c);
         got.err = err_irq;
         got.sa = irq_sa;
         cmp_xfer(got, xq.pop_front());
         c = 0;
         got = '0;
         n_done++;
      end
   end

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         num_errors++;
         report_and_stop();
      end
   end

   // ************************
   // stimulus
   // ************************
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   function automatic logic [15:0] fcyc(input int t);
      case (t)
         6: return 16'(3 * WCYC + 2 * BIT_CYC);
         7: return 16'(4 * WCYC);
         8: return 16'(2 * WCYC);
         9: return 16'(3 * WCYC + 2 * BIT_CYC);
         10: return 16'(3 * WCYC - 2 * BIT_CYC);
         default: return 16'(3 * WCYC);
      endcase
   endfunction

   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge ref_clk); while (!hreadyout);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : ~hwdata;
      do @(posedge ref_clk); while (!hreadyout);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rdq.push_back(e);
      ahb(a, 1'b0, 32'h0);
   endtask

   task automatic fault(input logic [3:0] t);
      rti_fault_t f;
      f = '0;
      f.ftype = t;
      f.sync = 6'h30;
      f.wpos = 6'h01;
      f.bpos = 5'h05;
      f.fault_bit_count = 2'h2;
      f.dev = 2'h3;
      f.gap = 7'h02;
      wr(A_FAULT, f);
   endtask

   task automatic xfer(input logic bc, input logic [4:0] sa, input logic [4:0] wc,
                       input logic [15:0] cyc, input logic [15:0] stw, input logic err,
                       input logic xbus);
      xq.push_back(rti_exp_t'{cyc, xbus, stw, err, sa});
      n_sent++;
      rti_bc_model_i.send(1'b0, bc, 1'b1, sa, wc);
      while (n_done != n_sent)
         @(posedge ref_clk);
   endtask

   initial
   begin
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      rnd = lfsr(rnd);
      // busy, broadcast and message error positions kept clear in the mask
      m = rnd & 16'hF7E7;
      rd(A_NEXT, 32'h0);
      rd(A_LAST, 32'h0);
      rd(A_SACTL, 32'h0);
      rd(8'h18, 32'h0);
      wr(A_SEL, 32'h1);
      wr(A_SACTL, {16'hFFFF, m});
      rd(A_SACTL, {16'h0007, m});
      $display("test registers done");
      xfer(1'b0, 5'h01, 5'h02, 16'(3 * WCYC), m, 1'b0, 1'b0);
      rd(A_LAST, {16'h0, m});
      $display("test clean done");
      for (int t = 1; t < 14; t++)
      begin
         fault(4'(t));
         xfer(1'b0, 5'h01, 5'h02, fcyc(t), m, 1'b1, t == 11);
         // the call above also per type
      end
      fault(4'h0);
      $display("test faults done");
      wr(A_NEXT, 32'h0800);
      xfer(1'b0, 5'h01, 5'h02, 16'(WCYC), 16'h0800 | m, 1'b0, 1'b0);
      wr(A_SEL, 32'h3);
      wr(A_SACTL, 32'h00030008);
      xfer(1'b0, 5'h03, 5'h05, 16'(WCYC), 16'h0808, 1'b0, 1'b0);
      $display("test status flags done");
      wr(A_NEXT, 32'h0);
      xfer(1'b1, 5'h01, 5'h02, 16'h0, 16'h0, 1'b0, 1'b0);
      xfer(1'b0, 5'h03, 5'h01, 16'(WCYC), 16'h0018, 1'b0, 1'b0);
      rd(A_LAST, 32'h00000018);
      $display("test broadcast done");
      report_and_stop();
   end
endmodule
`default_nettype wire
